// ---- rtl/phase_gen.sv ----
// Phase generator: steps a 64-position pixel phase and tracks lock.
// Assumes restart is a one-cycle pulse from the register block.
`timescale 1ns/1ps
`default_nettype none
module phase_gen
  import pst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  phase_if.gen pif
);

  typedef struct packed {
    dll_state_e state;
    logic [5:0] phase;
    logic [7:0] cnt;
    logic locked;
    logic lock_event;
  } gen_s;

  gen_s cur_r;
  gen_s cur_nxt;

  always_comb
  begin
    cur_nxt = cur_r;
    cur_nxt.lock_event = 1'b0;
    if (pif.restart)
    begin
      cur_nxt.state = DLL_RESET;
      cur_nxt.phase = 6'h00;
      cur_nxt.cnt = 8'h00;
      cur_nxt.locked = 1'b0;
    end
    else
    begin
      unique case (cur_r.state)
        DLL_RESET:
          cur_nxt.state = DLL_ACQUIRE;
        DLL_ACQUIRE:
        begin
          cur_nxt.phase = cur_r.phase + 6'h01;
          cur_nxt.cnt = cur_r.cnt + 8'h01;
          if (cur_r.cnt == LOCK_CYCLES - 8'h01)
          begin
            cur_nxt.state = DLL_LOCKED;
            cur_nxt.locked = 1'b1;
            cur_nxt.lock_event = 1'b1;
          end
        end
        DLL_LOCKED:
          cur_nxt.phase = cur_r.phase + 6'h01;
        default:
          cur_nxt.state = DLL_RESET;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_r <= '{DLL_RESET, 6'h00, 8'h00, 1'b0, 1'b0};
    else
      cur_r <= cur_nxt;
  end

  assign pif.phase = cur_r.phase;
  assign pif.locked = cur_r.locked;
  assign pif.lock_event = cur_r.lock_event;

  property p_lock_time;
    @(posedge pclk) disable iff (!presetn)
    pif.restart ##1 (!pif.restart) [*8] |-> !pif.locked;
  endproperty
  a_lock_time: assert property (p_lock_time) // [RL8]
    else $error("Lock reported too soon after a loop reset");

endmodule // phase_gen
`default_nettype wire

// ---- rtl/phase_if.sv ----
// Link between the register block and the phase generator.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic [5:0] phase;
  logic restart;
  logic locked;
  logic lock_event;
  modport gen (input restart, output phase, output locked,
               output lock_event);
  modport cons (output restart, input phase, input locked,
                input lock_event);
endinterface
`default_nettype wire

// ---- rtl/pixel_sample_timing_config.sv ----
// Clamp and sample pulse timing with its register file on APB.
// Assumes synchronous inputs; one pclk cycle is one phase position.
// Summary of operation
// RL1 - Clamp pulse rises at the clamp start index, 0 to 63.
// RL2 - Clamp pulse falls at the clamp end index, 0 to 63.
// RL3 - Clamp indexes act only in double sampling mode.
// RL4 - Sample pulse rises at the sample start index, 0 to 63.
// RL5 - Sample pulse falls at the sample end index, 0 to 63.
// RL6 - Loop range 10, 01, 00 picks lock band; 11 is reserved.
// RL7 - Input clock band codes 000 to 101; 110 and 111 unused.
// RL8 - Writing one resets the loop; the bit then clears itself.
// RL9 - Software writes all timing registers with baselines after power-up.
// RL10 - Index registers keep six bits; upper bits read zero.
// RL11 - Mode bit set selects sample-and-hold, clear double sampling.
// RL12 - Read-only flag reports loop locked at half frequency.
`timescale 1ns/1ps
`default_nettype none
module pixel_sample_timing_config
  import pst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic half_lock_in,
  output logic clamp_pulse,
  output logic sample_pulse,
  output logic dll_reset,
  output logic [1:0] dll_range,
  output logic [2:0] clock_band,
  output logic sample_hold_mode,
  output logic irq
);

  typedef struct packed {
    logic [5:0] clamp_rise;
    logic [5:0] clamp_fall;
    logic [5:0] samp_rise;
    logic [5:0] samp_fall;
    logic band_hi;
    logic [2:0] band;
    logic [1:0] band_mid;
    logic [1:0] dll_range;
    logic [6:0] dll_ctl_hi;
    logic dll_rst;
    logic [6:0] mode_lo;
    logic sh_mode;
    logic false_lock;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic clamp;
    logic sample;
  } regs_s;

  regs_s cur_r;
  regs_s cur_nxt;

  phase_if pif ();

  phase_gen u_phase_gen (
    .pclk(pclk),
    .presetn(presetn),
    .pif(pif.gen)
  );

  logic [7:0] idx;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [31:0] rd_word;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // Empty window when start equals end; wraps when start is past end
  function automatic logic in_window(
    input logic [5:0] ph,
    input logic [5:0] rise,
    input logic [5:0] fall
  );
    if (rise <= fall)
      in_window = (ph >= rise) && (ph < fall);
    else
      in_window = (ph >= rise) || (ph < fall);
  endfunction

  assign idx = paddr[9:2];
  assign setup = psel && !penable;
  assign access = psel && penable && cur_r.pready;
  assign wr = access && pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (idx)
      IDX_CLAMP_RISE:
        rd_word[5:0] = cur_r.clamp_rise; // [RL10]
      IDX_CLAMP_FALL:
        rd_word[5:0] = cur_r.clamp_fall; // [RL10]
      IDX_SAMP_RISE:
        rd_word[5:0] = cur_r.samp_rise; // [RL10]
      IDX_SAMP_FALL:
        rd_word[5:0] = cur_r.samp_fall; // [RL10]
      IDX_BAND:
        rd_word[7:0] = {cur_r.band_hi, cur_r.band,
                        cur_r.band_mid, cur_r.dll_range};
      IDX_DLL_CTL:
        rd_word[7:0] = {cur_r.dll_ctl_hi, cur_r.dll_rst};
      IDX_MODE:
        rd_word[7:0] = {cur_r.sh_mode, cur_r.mode_lo};
      IDX_LOCK_STAT:
        rd_word[FALSE_LOCK_BIT] = cur_r.false_lock; // [RL12]
      IDX_IRQ_STAT:
        rd_word[1:0] = cur_r.irq_stat;
      IDX_IRQ_MASK:
        rd_word[1:0] = cur_r.irq_mask;
      default:
        mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0)
      mapped = 1'b0;
  end

  // Events are the rise of the false lock flag and a completed lock
  always_comb
  begin
    irq_set = 2'h0;
    // No event while a loop reset is dropping the flag
    irq_set[IRQ_FALSE_LOCK] = !cur_r.false_lock && pif.locked
                              && half_lock_in && !cur_r.dll_rst; // [RL12]
    irq_set[IRQ_LOCKED] = pif.lock_event;
    irq_clr = 2'h0;
    // Only bits that were actually returned are cleared
    if (access && !pwrite && idx == IDX_IRQ_STAT && !cur_r.pslverr)
      irq_clr = cur_r.prdata[1:0];
  end

  always_comb
  begin
    cur_nxt = cur_r;
    // Answer one cycle after setup, so every access has one wait-free slot
    cur_nxt.pready = setup;
    cur_nxt.pslverr = setup && !mapped;
    if (setup)
      cur_nxt.prdata = mapped ? rd_word : 32'h0000_0000;
    else if (access)
      cur_nxt.prdata = 32'h0000_0000;
    // Self-clearing: the restart pulse is the reset being applied
    cur_nxt.dll_rst = 1'b0; // [RL8]
    if (wr && !cur_r.pslverr)
    begin
      unique case (idx)
        IDX_CLAMP_RISE:
          cur_nxt.clamp_rise = pwdata[5:0]; // [RL10]
        IDX_CLAMP_FALL:
          cur_nxt.clamp_fall = pwdata[5:0]; // [RL10]
        IDX_SAMP_RISE:
          cur_nxt.samp_rise = pwdata[5:0]; // [RL10]
        IDX_SAMP_FALL:
          cur_nxt.samp_fall = pwdata[5:0]; // [RL10]
        IDX_BAND:
        begin
          cur_nxt.band_hi = pwdata[7];
          cur_nxt.band_mid = pwdata[3:2];
          // Reserved codes are dropped, old field kept
          if (pwdata[BAND_LSB+:3] <= BAND_MAX)
            cur_nxt.band = pwdata[BAND_LSB+:3]; // [RL7]
          if (pwdata[1:0] != DLL_RANGE_RSVD)
            cur_nxt.dll_range = pwdata[1:0]; // [RL6]
        end
        IDX_DLL_CTL:
        begin
          cur_nxt.dll_ctl_hi = pwdata[7:1];
          cur_nxt.dll_rst = pwdata[DLL_RST_BIT]; // [RL8]
        end
        IDX_MODE:
        begin
          cur_nxt.sh_mode = pwdata[SH_BIT]; // [RL11]
          cur_nxt.mode_lo = pwdata[6:0];
        end
        IDX_IRQ_MASK:
          cur_nxt.irq_mask = pwdata[1:0];
        default:
          cur_nxt.irq_mask = cur_r.irq_mask;
      endcase
    end
    // Flag is sampled only once locked and dropped by a loop reset
    if (cur_r.dll_rst)
      cur_nxt.false_lock = 1'b0; // [RL12]
    else if (pif.locked && half_lock_in)
      cur_nxt.false_lock = 1'b1; // [RL12]
    // Set wins over a read clear in the same cycle
    cur_nxt.irq_stat = (cur_r.irq_stat & ~irq_clr) | irq_set;
    // Next mask too, so irq never lags a mask write
    cur_nxt.irq = |(cur_nxt.irq_stat & cur_nxt.irq_mask);
    // Clamp is held low in sample-and-hold mode
    cur_nxt.clamp = !cur_r.sh_mode
                    && in_window(pif.phase, cur_r.clamp_rise,
                                 cur_r.clamp_fall); // [RL1] [RL2] [RL3]
    cur_nxt.sample = in_window(pif.phase, cur_r.samp_rise,
                               cur_r.samp_fall); // [RL4] [RL5]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_r <= '0;
      cur_r.clamp_rise <= RST_CLAMP_RISE;
      cur_r.clamp_fall <= RST_CLAMP_FALL;
      cur_r.samp_rise <= RST_SAMP_RISE;
      cur_r.samp_fall <= RST_SAMP_FALL;
      cur_r.band_hi <= RST_BAND[7];
      cur_r.band <= RST_BAND[6:4];
      cur_r.band_mid <= RST_BAND[3:2];
      cur_r.dll_range <= RST_BAND[1:0];
      cur_r.dll_ctl_hi <= RST_DLL_CTL[7:1];
      // Loop reset runs once right after power-up
      cur_r.dll_rst <= RST_DLL_CTL[0];
      cur_r.sh_mode <= RST_MODE[7];
      cur_r.mode_lo <= RST_MODE[6:0];
      cur_r.irq_mask <= RST_IRQ_MASK;
    end
    else
      cur_r <= cur_nxt;
  end

  assign pif.restart = cur_r.dll_rst; // [RL8]

  assign prdata = cur_r.prdata;
  assign pready = cur_r.pready;
  assign pslverr = cur_r.pslverr;
  assign clamp_pulse = cur_r.clamp;
  assign sample_pulse = cur_r.sample;
  assign dll_reset = cur_r.dll_rst;
  assign dll_range = cur_r.dll_range;
  assign clock_band = cur_r.band;
  assign sample_hold_mode = cur_r.sh_mode;
  assign irq = cur_r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_clamp_sh;
    sample_hold_mode |=> !clamp_pulse;
  endproperty
  a_clamp_sh: assert property (p_clamp_sh) // [RL3]
    else $error("Clamp pulse active in sample-and-hold mode");

  property p_clamp_rise;
    (!sample_hold_mode && pif.phase == cur_r.clamp_rise
     && cur_r.clamp_rise != cur_r.clamp_fall) |=> clamp_pulse;
  endproperty
  a_clamp_rise: assert property (p_clamp_rise) // [RL1]
    else $error("Clamp pulse did not rise at its start index");

  property p_clamp_fall;
    (pif.phase == cur_r.clamp_fall) |=> !clamp_pulse;
  endproperty
  a_clamp_fall: assert property (p_clamp_fall) // [RL2]
    else $error("Clamp pulse did not fall at its end index");

  property p_samp_rise;
    (pif.phase == cur_r.samp_rise && cur_r.samp_rise != cur_r.samp_fall)
    |=> sample_pulse;
  endproperty
  a_samp_rise: assert property (p_samp_rise) // [RL4]
    else $error("Sample pulse did not rise at its start index");

  property p_samp_fall;
    (pif.phase == cur_r.samp_fall) |=> !sample_pulse;
  endproperty
  a_samp_fall: assert property (p_samp_fall) // [RL5]
    else $error("Sample pulse did not fall at its end index");

  property p_range_rsvd;
    (wr && idx == IDX_BAND && pwdata[1:0] == DLL_RANGE_RSVD)
    |=> dll_range == $past(dll_range);
  endproperty
  a_range_rsvd: assert property (p_range_rsvd) // [RL6]
    else $error("Reserved loop range code was stored");

  property p_band_rsvd;
    (wr && idx == IDX_BAND && pwdata[6:4] > BAND_MAX)
    |=> clock_band == $past(clock_band);
  endproperty
  a_band_rsvd: assert property (p_band_rsvd) // [RL7]
    else $error("Unused input clock band code was stored");

  property p_dll_selfclr;
    (wr && idx == IDX_DLL_CTL && pwdata[0])
    |=> dll_reset ##1 !dll_reset ##1 !pif.locked;
  endproperty
  a_dll_selfclr: assert property (p_dll_selfclr) // [RL8]
    else $error("Loop reset bit did not pulse and clear");

  property p_index_mask;
    (pready && !pslverr && idx >= IDX_CLAMP_RISE
     && idx <= IDX_SAMP_FALL) |-> prdata[31:6] == 26'h0;
  endproperty
  a_index_mask: assert property (p_index_mask) // [RL10]
    else $error("Index register upper bits read nonzero");

  property p_false_lock;
    (pif.locked && half_lock_in && !dll_reset && !cur_r.false_lock)
    |=> cur_r.false_lock && cur_r.irq_stat[IRQ_FALSE_LOCK];
  endproperty
  a_false_lock: assert property (p_false_lock) // [RL12]
    else $error("False lock not reported in status");

  property p_irq_level;
    irq == |(cur_r.irq_stat & cur_r.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt low with unmasked status set");

  c_clamp_pulse: cover property (!clamp_pulse ##1 clamp_pulse);
  c_dll_reset: cover property ($rose(dll_reset));
  c_locked: cover property (pif.lock_event);
  c_sh_mode: cover property ($rose(sample_hold_mode));

endmodule // pixel_sample_timing_config
`default_nettype wire

// ---- rtl/pst_pkg.sv ----
// Constants and types for the pixel sample timing configuration block.
// Assumes one 25 MHz clock; each phase position is one clock cycle.
package pst_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CLAMP_RISE = 8'h20;
  localparam logic [7:0] IDX_CLAMP_FALL = 8'h21;
  localparam logic [7:0] IDX_SAMP_RISE = 8'h22;
  localparam logic [7:0] IDX_SAMP_FALL = 8'h23;
  localparam logic [7:0] IDX_BAND = 8'h25;
  localparam logic [7:0] IDX_DLL_CTL = 8'h28;
  localparam logic [7:0] IDX_MODE = 8'h29;
  localparam logic [7:0] IDX_LOCK_STAT = 8'h2a;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h2b;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h2c;

  // Values after reset
  localparam logic [5:0] RST_CLAMP_RISE = 6'h08;
  localparam logic [5:0] RST_CLAMP_FALL = 6'h1c;
  localparam logic [5:0] RST_SAMP_RISE = 6'h28;
  localparam logic [5:0] RST_SAMP_FALL = 6'h3c;
  localparam logic [7:0] RST_BAND = 8'h02;
  localparam logic [7:0] RST_DLL_CTL = 8'h0f;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // Field positions and codes
  localparam int BAND_LSB = 4;
  localparam int SH_BIT = 7;
  localparam int DLL_RST_BIT = 0;
  localparam int FALSE_LOCK_BIT = 0;
  localparam int IRQ_FALSE_LOCK = 0;
  localparam int IRQ_LOCKED = 1;
  localparam logic [1:0] DLL_RANGE_RSVD = 2'h3;
  localparam logic [2:0] BAND_MAX = 3'h5;

  // Phase positions per pixel period and lock acquisition time
  localparam int PHASES = 64;
  localparam logic [7:0] LOCK_CYCLES = 8'h80;

  typedef enum logic [1:0] {
    DLL_RESET = 2'b00,
    DLL_ACQUIRE = 2'b01,
    DLL_LOCKED = 2'b11
  } dll_state_e;

endpackage

// ---- test/loop_model.sv ----
// Behavioural analog loop beside the timing block.
// Assumes dll_reset is the block's one-cycle loop reset pulse.
`timescale 1ns/1ps
`default_nettype none
module loop_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic force_half,
  input wire logic dll_reset,
  output logic half_lock_in
);
  // Half lock holds until a loop reset, as a real loop would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      half_lock_in <= 1'b0;
    else if (dll_reset)
      half_lock_in <= 1'b0;
    else if (force_half)
      half_lock_in <= 1'b1;
  end
endmodule // loop_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench: APB register tasks and pulse measurements.
// Assumes a registered APB slave; the master waits for pready.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pst_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic force_half = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, half_lock_in, clamp_pulse, sample_pulse, err;
  logic dll_reset, sample_hold_mode, irq;
  logic [1:0] dll_range;
  logic [2:0] clock_band;
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] ix[6] = '{IDX_CLAMP_RISE, IDX_CLAMP_FALL, IDX_SAMP_RISE,
                        IDX_SAMP_FALL, IDX_BAND, IDX_DLL_CTL};
  logic [31:0] bv[6] = '{32'h08, 32'h1c, 32'h28, 32'h3c, 32'h02, 32'h0e};
  logic [31:0] cr_t[4] = '{32'h08, 32'h00, 32'h3f, 32'h08};
  logic [31:0] cf_t[4] = '{32'h1c, 32'h3f, 32'h00, 32'h1c};
  logic [31:0] sr_t[4] = '{32'h28, 32'h32, 32'h0a, 32'h28};
  logic [31:0] sf_t[4] = '{32'h3c, 32'h05, 32'h0a, 32'h3c};
  logic [31:0] md_t[4] = '{32'h00, 32'h00, 32'h00, 32'h80};

  pixel_sample_timing_config pixel_sample_timing_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .half_lock_in(half_lock_in),
    .clamp_pulse(clamp_pulse), .sample_pulse(sample_pulse),
    .dll_reset(dll_reset), .dll_range(dll_range), .clock_band(clock_band),
    .sample_hold_mode(sample_hold_mode), .irq(irq)
  );
  loop_model loop_model_inst (
    .pclk(pclk), .presetn(presetn), .force_half(force_half),
    .dll_reset(dll_reset), .half_lock_in(half_lock_in)
  );

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  task automatic pulse_count(output int c);
    c = 0;
    repeat (4)
    begin
      @(negedge pclk);
      if (dll_reset === 1'b1)
        c++;
    end
  endtask

  function automatic int width(input logic [31:0] r, input logic [31:0] f);
    return (r <= f) ? int'(f - r) : PHASES - int'(r - f);
  endfunction

  // Two pixel periods, so every pulse with a non-empty window, bar the clamp in sample-and-hold mode, rises at least once
  task automatic measure(output int cw, output int sw, output int gap);
    int cr, sr;
    logic pc, ps;
    cw = 0;
    sw = 0;
    cr = 0;
    sr = 0;
    repeat (4) @(negedge pclk);
    pc = clamp_pulse;
    ps = sample_pulse;
    for (int i = 0; i < 128; i++)
    begin
      @(negedge pclk);
      if (clamp_pulse === 1'b1)
        cw++;
      if (sample_pulse === 1'b1)
        sw++;
      if (clamp_pulse === 1'b1 && pc !== 1'b1)
        cr = i;
      if (sample_pulse === 1'b1 && ps !== 1'b1)
        sr = i;
      pc = clamp_pulse;
      ps = sample_pulse;
    end
    gap = (sr - cr + 128) % 64;
  endtask

  initial
  begin : main
    int cw, sw, gp, c, ec;
    logic [2:0] eb;
    logic [1:0] er;
    eb = 3'h0;
    er = 2'h2;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(ix[i], bv[i]);
    // Loop baseline has the reset bit set, so the loop relocks here
    for (int i = 0; i < 6; i++)
      wr(ix[i], (i == 5) ? 32'h0f : bv[i]);
    wr(IDX_CLAMP_RISE, 32'hff);
    rdc(IDX_CLAMP_RISE, 32'h3f);
    apb(1'b0, 8'h24, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // Reserved codes must leave the field as it was
    for (int b = 0; b < 8; b++)
      for (int r = 0; r < 4; r++)
      begin
        wr(IDX_BAND, 32'(b * 16 + r));
        if (b <= BAND_MAX)
          eb = b[2:0];
        if (r != DLL_RANGE_RSVD)
          er = r[1:0];
        repeat (2) @(negedge pclk);
        check({29'h0, clock_band}, {29'h0, eb});
        check({30'h0, dll_range}, {30'h0, er});
      end
    rdc(IDX_BAND, 32'h52);
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_CLAMP_RISE, cr_t[k]);
      wr(IDX_CLAMP_FALL, cf_t[k]);
      wr(IDX_SAMP_RISE, sr_t[k]);
      wr(IDX_SAMP_FALL, sf_t[k]);
      wr(IDX_MODE, md_t[k]);
      measure(cw, sw, gp);
      ec = md_t[k][7] ? 0 : 2 * width(cr_t[k], cf_t[k]);
      check(32'(cw), 32'(ec));
      check(32'(sw), 32'(2 * width(sr_t[k], sf_t[k])));
      check({31'h0, sample_hold_mode}, {31'h0, md_t[k][7]});
      if (cw > 0 && sw > 0)
        check(32'(gp), (sr_t[k] - cr_t[k]) & 32'h3f);
    end
    check({31'h0, irq}, 32'h0);
    rdc(IDX_IRQ_STAT, 32'h2);
    rdc(IDX_IRQ_STAT, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    @(posedge pclk);
    force_half <= 1'b1;
    @(posedge pclk);
    force_half <= 1'b0;
    repeat (3) @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    rdc(IDX_LOCK_STAT, 32'h1);
    rdc(IDX_IRQ_STAT, 32'h1);
    repeat (3) @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(IDX_DLL_CTL, 32'h1);
    pulse_count(c);
    check(32'(c), 32'h1);
    rdc(IDX_DLL_CTL, 32'h0);
    rdc(IDX_LOCK_STAT, 32'h0);
    print_verdict();
  end

  initial
  begin
    repeat (6000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
